// >>> hw/eei_pkg.sv
package eei_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam int          ADDR_W        = 14;
   localparam int          DATA_W        = 32;
   localparam int          IDX_W         = 12;
   localparam int          IDX_LSB       = 2;
   localparam logic [11:0] IDX_EXT0_MODE = 12'hfb4;
   localparam logic [11:0] IDX_EXT1_MODE = 12'hfb5;
   localparam logic [11:0] IDX_KEY_MODE  = 12'hfb6;
   localparam logic [11:0] IDX_WATCH     = 12'hfba;
   localparam logic [11:0] IDX_IRQ_STAT  = 12'hfbc;
   localparam logic [11:0] IDX_IRQ_MASK  = 12'hfbd;
   localparam logic [11:0] IDX_REQ_FLAGS = 12'hfbe;
   localparam logic [11:0] IDX_EXT2_MODE = 12'hfda;

   // ----------------------------------------------------------------
   // field positions, codes and reset values
   // ----------------------------------------------------------------
   localparam int          WATCH_REQ_BIT = 0;
   localparam int          WATCH_EN_BIT  = 1;
   localparam int          EXT_SEL_BIT   = 0;
   localparam int          KEY_EDGE_BIT  = 2;
   localparam int          EV_EXT0       = 0;
   localparam int          EV_EXT1       = 1;
   localparam int          EV_EXT2       = 2;
   localparam int          EV_KEY        = 3;
   localparam int          EV_WATCH      = 4;
   localparam int          NUM_EV        = 5;
   localparam int          NUM_ACK       = 4;
   localparam int          NUM_KEYS      = 8;
   localparam logic [1:0]  MODE_RISE     = 2'h0;
   localparam logic [1:0]  MODE_FALL     = 2'h1;
   localparam logic [1:0]  MODE_BOTH     = 2'h2;
   localparam logic [1:0]  MODE_NONE     = 2'h3;
   localparam logic [1:0]  KSEL_OFF      = 2'h0;
   localparam logic [1:0]  KSEL_LOW      = 2'h1;
   localparam logic [1:0]  KSEL_HIGH     = 2'h2;
   localparam logic [1:0]  KSEL_ALL      = 2'h3;
   localparam logic [7:0]  KEYS_LOW      = 8'h0f;
   localparam logic [7:0]  KEYS_HIGH     = 8'hf0;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   localparam logic [1:0]  SYNC_ARMED    = 2'h3;
   localparam logic [3:0]  MODE_RST      = 4'h0;

endpackage

// >>> hw/eei_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module eei_pin_sync
   import eei_pkg::*;
#(
   parameter int W = 11
) (
   input  wire logic         sys_clk_in,
   input  wire logic         srst_in,
   input  wire logic         ce_in,
   input  wire logic [W-1:0] pins_in,
   output logic      [W-1:0] rise_out,
   output logic      [W-1:0] fall_out
);

   // ----------------------------------------------------------------
   // two-flop synchroniser plus one history stage
   // ----------------------------------------------------------------
   logic [W-1:0] meta_q, meta_d;
   logic [W-1:0] sync_q, sync_d;
   logic [W-1:0] hist_q, hist_d;
   logic [1:0]   arm_q,  arm_d;

   // meta stage feeds only the sync stage
   always_comb begin
      meta_d = pins_in;
      sync_d = meta_q;
      hist_d = sync_q;
      arm_d  = (arm_q == SYNC_ARMED) ? arm_q : arm_q + 2'h1;
   end

   // edges are held off until history holds a real pin level
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         meta_q <= '0;
         sync_q <= '0;
         hist_q <= '0;
         arm_q  <= '0;
      end else if (ce_in) begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         hist_q <= hist_d;
         arm_q  <= arm_d;
      end
   end

   // one pulse per level change, qualified by clock enable
   assign rise_out = (arm_q == SYNC_ARMED && ce_in) ? (sync_q & ~hist_q) : '0;
   assign fall_out = (arm_q == SYNC_ARMED && ce_in) ? (~sync_q & hist_q) : '0;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_edge_once;
      @(posedge sys_clk_in) disable iff (srst_in)
      ((rise_out | fall_out) != '0) && ce_in
         |=> (((rise_out & $past(rise_out)) |
               (fall_out & $past(fall_out))) == '0);
   endproperty
   a_edge_once: assert property (p_edge_once) else $error("edge pulse repeated");

endmodule

`default_nettype wire

// >>> hw/eei_irq_mode.sv
`timescale 1ns/1ps
`default_nettype none

module eei_irq_mode
   import eei_pkg::*;
(
   input  wire logic              sys_clk_in,
   input  wire logic              srst_in,
   input  wire logic              ce_in,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
   input  wire logic              s_axi_awvalid_in,
   output logic                   s_axi_awready_out,
   input  wire logic [DATA_W-1:0] s_axi_wdata_in,
   input  wire logic [3:0]        s_axi_wstrb_in,
   input  wire logic              s_axi_wvalid_in,
   output logic                   s_axi_wready_out,
   output logic [1:0]             s_axi_bresp_out,
   output logic                   s_axi_bvalid_out,
   input  wire logic              s_axi_bready_in,
   input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
   input  wire logic              s_axi_arvalid_in,
   output logic                   s_axi_arready_out,
   output logic [DATA_W-1:0]      s_axi_rdata_out,
   output logic [1:0]             s_axi_rresp_out,
   output logic                   s_axi_rvalid_out,
   input  wire logic              s_axi_rready_in,
   input  wire logic              ext_irq_pin_zero_in,
   input  wire logic              ext_irq_pin_one_in,
   input  wire logic              ext_irq_pin_two_in,
   input  wire logic [7:0]        key_input_pins_in,
   input  wire logic [7:0]        key_pin_is_output_in,
   input  wire logic              watch_interval_interrupt_in,
   input  wire logic [3:0]        svc_ack_in,
   output logic                   ext0_request_flag_out,
   output logic                   ext1_request_flag_out,
   output logic                   ext2_request_flag_out,
   output logic                   keypad_request_flag_out,
   output logic                   watch_irq_request_out,
   output logic                   irq_out
);

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic [IDX_W-1:0] word_idx(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:IDX_LSB];
   endfunction

   function automatic logic [7:0] key_mask(input logic [1:0] sel);
      logic [7:0] m;
      m = '0;
      case (sel)
         KSEL_LOW:  m = KEYS_LOW;
         KSEL_HIGH: m = KEYS_HIGH;
         KSEL_ALL:  m = KEYS_LOW | KEYS_HIGH;
         default:   m = '0;
      endcase
      return m;
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisation and edge pulses
   // ----------------------------------------------------------------
   logic [10:0] rise_v;
   logic [10:0] fall_v;

   eei_pin_sync #(
      .W (11)
   ) u_sync (
      .sys_clk_in (sys_clk_in),
      .srst_in    (srst_in),
      .ce_in      (ce_in),
      .pins_in    ({key_input_pins_in, ext_irq_pin_two_in,
                    ext_irq_pin_one_in, ext_irq_pin_zero_in}),
      .rise_out   (rise_v),
      .fall_out   (fall_v)
   );

   // ----------------------------------------------------------------
   // bus slave: write and read channels
   // ----------------------------------------------------------------
   logic                    aw_hold_q, aw_hold_d;
   logic                    w_hold_q,  w_hold_d;
   logic [ADDR_W-1:0]       aw_addr_q, aw_addr_d;
   logic [DATA_W-1:0]       w_data_q,  w_data_d;
   logic [3:0]              w_strb_q,  w_strb_d;
   logic                    bvalid_q,  bvalid_d;
   logic [1:0]              bresp_q,   bresp_d;
   logic                    rvalid_q,  rvalid_d;
   logic [1:0]              rresp_q,   rresp_d;
   logic [DATA_W-1:0]       rdata_q,   rdata_d;
   logic                    aw_have, w_have, wr_go, rd_go, wr_en;
   logic [IDX_W-1:0]        wr_idx, rd_idx;
   logic [DATA_W-1:0]       wr_data;
   logic                    wr_hit, rd_hit;
   // register state sits here so the read mux below can see it
   logic [1:0]              ext0_mode_q, ext0_mode_d;
   logic                    ext1_sel_q,  ext1_sel_d;
   logic                    ext2_sel_q,  ext2_sel_d;
   logic [2:0]              key_mode_q,  key_mode_d;
   logic                    watch_en_q,  watch_en_d;
   logic [NUM_EV-1:0]       mask_q,      mask_d;
   logic [NUM_ACK-1:0]      req_q,       req_d;
   logic                    watch_req_q, watch_req_d;
   logic [NUM_EV-1:0]       stat_q,      stat_d;

   assign s_axi_awready_out = ~aw_hold_q & ~bvalid_q & ce_in;
   assign s_axi_wready_out  = ~w_hold_q & ~bvalid_q & ce_in;
   assign s_axi_arready_out = ~rvalid_q & ce_in;
   assign aw_have = aw_hold_q | (s_axi_awvalid_in & s_axi_awready_out);
   assign w_have  = w_hold_q | (s_axi_wvalid_in & s_axi_wready_out);
   assign wr_go   = aw_have & w_have;
   assign rd_go   = s_axi_arvalid_in & s_axi_arready_out;
   assign wr_idx  = word_idx(aw_hold_q ? aw_addr_q : s_axi_awaddr_in);
   assign wr_data = w_hold_q ? w_data_q : s_axi_wdata_in;
   // only the low byte lane carries register bits
   assign wr_en   = wr_go & (w_hold_q ? w_strb_q[0] : s_axi_wstrb_in[0]);
   assign rd_idx  = word_idx(s_axi_araddr_in);

   // address and data may arrive in either order
   always_comb begin
      aw_hold_d = wr_go ? 1'b0 : aw_have;
      w_hold_d  = wr_go ? 1'b0 : w_have;
      aw_addr_d = (aw_hold_q) ? aw_addr_q : s_axi_awaddr_in;
      w_data_d  = (w_hold_q) ? w_data_q : s_axi_wdata_in;
      w_strb_d  = (w_hold_q) ? w_strb_q : s_axi_wstrb_in;
      bvalid_d  = wr_go | (bvalid_q & ~s_axi_bready_in);
      bresp_d   = wr_go ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : bresp_q;
      rvalid_d  = rd_go | (rvalid_q & ~s_axi_rready_in);
      rresp_d   = rd_go ? (rd_hit ? RESP_OKAY : RESP_SLVERR) : rresp_q;
      rdata_d   = rdata_q;
      if (rd_go) begin
         rdata_d = '0;
         case (rd_idx)
            IDX_WATCH:     rdata_d[1:0] = {watch_en_q, watch_req_q};
            IDX_IRQ_STAT:  rdata_d[NUM_EV-1:0] = stat_q;
            IDX_IRQ_MASK:  rdata_d[NUM_EV-1:0] = mask_q;
            IDX_REQ_FLAGS: rdata_d[NUM_ACK-1:0] = req_q;
            default:       rdata_d = '0; // write-only modes read zero
         endcase
      end
   end

   // registered bus state
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         aw_addr_q <= '0;
         w_data_q  <= '0;
         w_strb_q  <= '0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         rvalid_q  <= 1'b0;
         rresp_q   <= RESP_OKAY;
         rdata_q   <= '0;
      end else if (ce_in) begin
         aw_hold_q <= aw_hold_d;
         w_hold_q  <= w_hold_d;
         aw_addr_q <= aw_addr_d;
         w_data_q  <= w_data_d;
         w_strb_q  <= w_strb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rresp_q   <= rresp_d;
         rdata_q   <= rdata_d;
      end
   end

   assign s_axi_bvalid_out = bvalid_q;
   assign s_axi_bresp_out  = bresp_q;
   assign s_axi_rvalid_out = rvalid_q;
   assign s_axi_rresp_out  = rresp_q;
   assign s_axi_rdata_out  = rdata_q;

   // ----------------------------------------------------------------
   // mode, enable and mask registers
   // ----------------------------------------------------------------

   always_comb begin
      wr_hit = 1'b1;
      case (wr_idx)
         IDX_EXT0_MODE, IDX_EXT1_MODE, IDX_KEY_MODE, IDX_WATCH,
         IDX_IRQ_STAT, IDX_IRQ_MASK, IDX_REQ_FLAGS, IDX_EXT2_MODE: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
      rd_hit = 1'b1;
      case (rd_idx)
         IDX_EXT0_MODE, IDX_EXT1_MODE, IDX_KEY_MODE, IDX_WATCH,
         IDX_IRQ_STAT, IDX_IRQ_MASK, IDX_REQ_FLAGS, IDX_EXT2_MODE: rd_hit = 1'b1;
         default: rd_hit = 1'b0;
      endcase
   end

   // only the defined bits are stored, so upper bits stay zero
   always_comb begin
      ext0_mode_d = ext0_mode_q;
      ext1_sel_d  = ext1_sel_q;
      ext2_sel_d  = ext2_sel_q;
      key_mode_d  = key_mode_q;
      watch_en_d  = watch_en_q;
      mask_d      = mask_q;
      if (wr_en) begin
         case (wr_idx)
            IDX_EXT0_MODE: ext0_mode_d = wr_data[1:0];
            IDX_EXT1_MODE: ext1_sel_d  = wr_data[EXT_SEL_BIT];
            IDX_EXT2_MODE: ext2_sel_d  = wr_data[EXT_SEL_BIT];
            IDX_KEY_MODE:  key_mode_d  = wr_data[2:0];
            IDX_WATCH:     watch_en_d  = wr_data[WATCH_EN_BIT];
            IDX_IRQ_MASK:  mask_d      = wr_data[NUM_EV-1:0];
            default:       mask_d      = mask_q;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         ext0_mode_q <= MODE_RST[1:0];
         ext1_sel_q  <= MODE_RST[0];
         ext2_sel_q  <= MODE_RST[0];
         key_mode_q  <= MODE_RST[2:0];
         watch_en_q  <= 1'b0;
         mask_q      <= '0;
      end else if (ce_in) begin
         ext0_mode_q <= ext0_mode_d;
         ext1_sel_q  <= ext1_sel_d;
         ext2_sel_q  <= ext2_sel_d;
         key_mode_q  <= key_mode_d;
         watch_en_q  <= watch_en_d;
         mask_q      <= mask_d;
      end
   end

   // ----------------------------------------------------------------
   // edge selection per source
   // ----------------------------------------------------------------
   logic [7:0]        keys_on;
   logic              key_use_rise;
   logic [NUM_EV-1:0] ev;

   assign keys_on      = key_mask(key_mode_q[1:0]);
   // a driven pin among the selected keys masks rising detection
   assign key_use_rise = key_mode_q[KEY_EDGE_BIT] &
                         ~|(keys_on & key_pin_is_output_in);

   always_comb begin
      ev = '0;
      case (ext0_mode_q)
         MODE_RISE: ev[EV_EXT0] = rise_v[0];
         MODE_FALL: ev[EV_EXT0] = fall_v[0];
         MODE_BOTH: ev[EV_EXT0] = rise_v[0] | fall_v[0];
         default:   ev[EV_EXT0] = 1'b0;
      endcase
      ev[EV_EXT1]  = ext1_sel_q ? fall_v[1] : rise_v[1];
      ev[EV_EXT2]  = ext2_sel_q ? fall_v[2] : rise_v[2];
      ev[EV_KEY]   = |(keys_on & (key_use_rise ? rise_v[10:3] : fall_v[10:3]));
      ev[EV_WATCH] = watch_interval_interrupt_in & ce_in;
   end

   // ----------------------------------------------------------------
   // request flags, status and interrupt line
   // ----------------------------------------------------------------
   // set wins over a same-cycle clear everywhere
   always_comb begin
      req_d       = (req_q & ~svc_ack_in) | ev[NUM_ACK-1:0];
      watch_req_d = watch_req_q;
      if (wr_en && wr_idx == IDX_WATCH) begin
         watch_req_d = wr_data[WATCH_REQ_BIT];
      end
      watch_req_d = watch_req_d | ev[EV_WATCH];
      stat_d      = stat_q | ev;
      if (wr_en && wr_idx == IDX_IRQ_STAT) begin
         stat_d = (stat_q & ~wr_data[NUM_EV-1:0]) | ev;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         req_q       <= '0;
         watch_req_q <= 1'b0;
         stat_q      <= '0;
      end else if (ce_in) begin
         req_q       <= req_d;
         watch_req_q <= watch_req_d;
         stat_q      <= stat_d;
      end
   end

   assign ext0_request_flag_out   = req_q[EV_EXT0];
   assign ext1_request_flag_out   = req_q[EV_EXT1];
   assign ext2_request_flag_out   = req_q[EV_EXT2];
   assign keypad_request_flag_out = req_q[EV_KEY];
   assign watch_irq_request_out   = watch_req_q & watch_en_q;
   assign irq_out                 = |(stat_q & mask_q);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);

   sequence s_watch_hit;
      ce_in && watch_interval_interrupt_in;
   endsequence
   sequence s_watch_stays;
      watch_req_q [*2];
   endsequence

   property p_watch_set;
      s_watch_hit |=> watch_req_q ##0 stat_q[EV_WATCH];
   endproperty
   a_watch_set: assert property (p_watch_set) else $error("watch flag not set");

   property p_watch_no_autoclr;
      watch_req_q && ce_in && !(wr_en && wr_idx == IDX_WATCH) |-> s_watch_stays;
   endproperty
   a_watch_no_autoclr: assert property (p_watch_no_autoclr) else $error("watch flag self-cleared");

   property p_watch_gate;
      !watch_en_q |-> !watch_irq_request_out;
   endproperty
   a_watch_gate: assert property (p_watch_gate) else $error("watch request leaked");

   property p_ext0_rise;
      ce_in && ext0_mode_q == MODE_RISE && rise_v[0] |=> req_q[EV_EXT0];
   endproperty
   a_ext0_rise: assert property (p_ext0_rise) else $error("ext0 rise missed");

   property p_ext0_fall_only;
      ce_in && ext0_mode_q == MODE_FALL && !req_q[EV_EXT0] && !fall_v[0]
         |=> !req_q[EV_EXT0];
   endproperty
   a_ext0_fall_only: assert property (p_ext0_fall_only) else $error("ext0 set w/o fall");

   property p_ext0_both;
      ce_in && ext0_mode_q == MODE_BOTH && (rise_v[0] || fall_v[0]) |=> req_q[EV_EXT0];
   endproperty
   a_ext0_both: assert property (p_ext0_both) else $error("ext0 edge missed");

   property p_ext0_none;
      ce_in && ext0_mode_q == MODE_NONE && !req_q[EV_EXT0] |=> !req_q[EV_EXT0];
   endproperty
   a_ext0_none: assert property (p_ext0_none) else $error("ext0 set in mode 11");

   property p_ext1_sel;
      ce_in && (ext1_sel_q ? fall_v[1] : rise_v[1]) |=> $past(ev[EV_EXT1]) && req_q[EV_EXT1];
   endproperty
   a_ext1_sel: assert property (p_ext1_sel) else $error("ext1 edge missed");

   property p_ext2_sel;
      ce_in && (ext2_sel_q ? fall_v[2] : rise_v[2]) |=> req_q[EV_EXT2];
   endproperty
   a_ext2_sel: assert property (p_ext2_sel) else $error("ext2 edge missed");

   property p_key_off;
      key_mode_q[1:0] == KSEL_OFF |-> !ev[EV_KEY];
   endproperty
   a_key_off: assert property (p_key_off) else $error("key event while off");

   property p_key_out_fall;
      |(keys_on & key_pin_is_output_in) && !(|(keys_on & fall_v[10:3])) |-> !ev[EV_KEY];
   endproperty
   a_key_out_fall: assert property (p_key_out_fall) else $error("key rise with output pin");

   property p_key_flag;
      ce_in && ev[EV_KEY] |=> req_q[EV_KEY] && stat_q[EV_KEY];
   endproperty
   a_key_flag: assert property (p_key_flag) else $error("key flag not set");

   property p_read_upper_zero;
      rvalid_q |-> rdata_q[DATA_W-1:NUM_EV] == '0;
   endproperty
   a_read_upper_zero: assert property (p_read_upper_zero) else $error("upper read bits set");

   property p_write_answer;
      ce_in && wr_go |=> bvalid_q ##0 (bresp_q == $past(wr_hit ? RESP_OKAY : RESP_SLVERR));
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("write not answered");

endmodule

`default_nettype wire

// >>> dv/eei_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// far-side pin model
// ------------------------------------------------
module eei_pin_model (
   input  wire logic        sys_clk_in,
   input  wire logic [10:0] lvl_in,
   output logic      [2:0]  ext_out,
   output logic      [7:0]  key_out
);
   // pins move only just after an edge, like a real driver
   always_ff @(posedge sys_clk_in) begin
      ext_out <= lvl_in[2:0];
      key_out <= lvl_in[10:3];
   end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import eei_pkg::*;;
   // ------------------------------------------------
   // bench signals
   // ------------------------------------------------
   logic clk, srst, awv, wv, bry, arv, rry, tick, na, nw, a, w, ce;
   logic [13:0] awa, ara;
   logic [31:0] wd, rdt, rdv;
   logic [1:0]  br, rr, resp;
   logic [3:0]  ack, ws;
   logic [7:0]  kdir, key;
   logic [10:0] lvl;
   logic [2:0]  ext;
   logic        awr, wr_r, bv, arr, rv, wreq, irq;
   wire  [3:0]  fl;
   int          num_errors, compares, p;
   logic [11:0] idx [8] = '{IDX_EXT0_MODE, IDX_EXT1_MODE, IDX_KEY_MODE,
      IDX_WATCH, IDX_IRQ_STAT, IDX_IRQ_MASK, IDX_REQ_FLAGS, IDX_EXT2_MODE};

   eei_pin_model i_eei_pin_model (.sys_clk_in(clk), .lvl_in(lvl),
      .ext_out(ext), .key_out(key));
   eei_irq_mode i_eei_irq_mode (.sys_clk_in(clk), .srst_in(srst),
      .ce_in(ce), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
      .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_r), .s_axi_bresp_out(br),
      .s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_araddr_in(ara),
      .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rdt), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
      .s_axi_rready_in(rry), .ext_irq_pin_zero_in(ext[0]),
      .ext_irq_pin_one_in(ext[1]), .ext_irq_pin_two_in(ext[2]),
      .key_input_pins_in(key), .key_pin_is_output_in(kdir),
      .watch_interval_interrupt_in(tick), .svc_ack_in(ack),
      .ext0_request_flag_out(fl[0]), .ext1_request_flag_out(fl[1]),
      .ext2_request_flag_out(fl[2]), .keypad_request_flag_out(fl[3]),
      .watch_irq_request_out(wreq), .irq_out(irq));

   // 10 MHz clock
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end

   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         num_errors++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // readies are sampled at the falling edge to stay clear of races
   task wreg(input logic [11:0] i, input logic [31:0] d);
      a = 0;
      w = 0;
      @(posedge clk);
      awa <= {i, 2'h0};
      wd <= d;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      while (!(a && w)) begin
         @(negedge clk);
         na = awr && !a;
         nw = wr_r && !w;
         @(posedge clk);
         if (na) awv <= 0;
         if (nw) wv <= 0;
         a = a | na;
         w = w | nw;
      end
      @(negedge clk);
      while (!bv) @(negedge clk);
      resp = br;
      @(posedge clk);
      bry <= 0;
   endtask
   task rreg(input logic [11:0] i);
      @(posedge clk);
      ara <= {i, 2'h0};
      arv <= 1;
      rry <= 1;
      @(negedge clk);
      while (!arr) @(negedge clk);
      @(posedge clk);
      arv <= 0;
      @(negedge clk);
      while (!rv) @(negedge clk);
      rdv = rdt;
      resp = rr;
      @(posedge clk);
      rry <= 0;
   endtask
   task clr;
      ack <= 4'hf;
      @(posedge clk);
      ack <= 4'h0;
   endtask
   task pulse;
      tick <= 1;
      @(posedge clk);
      tick <= 0;
      cyc(2);
   endtask
   // flip a pin, check the flag against the expected value, then make sure it never repeats
   task tog(input int pin, input int f, input logic e);
      lvl[pin] <= ~lvl[pin];
      cyc(6);
      chk("flag", e, fl[f]);
      clr;
      cyc(6);
      chk("flag_once", 0, fl[f]);
   endtask
   function logic f_ext0(logic [1:0] m, logic r);
      return m == MODE_BOTH || m == (r ? MODE_RISE : MODE_FALL);
   endfunction
   function logic f_key(logic [1:0] s, int q);
      return s == KSEL_ALL || (s == KSEL_LOW && q < 4) ||
         (s == KSEL_HIGH && q > 3);
   endfunction
   task end_of_test;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      {srst, awv, wv, bry, arv, rry, tick} = 7'h40;
      {awa, ara, wd, ack, kdir, lvl} = '0;
      ce = 1;
      ws = 4'hf;
      num_errors = 0;
      compares = 0;
      void'($urandom(32'hc344));
      cyc(16);
      srst <= 0;
      cyc(4);
      foreach (idx[j]) begin
         rreg(idx[j]);
         chk("reset", 0, rdv);
      end
      wreg(IDX_EXT0_MODE, 32'hffffffff);
      rreg(IDX_EXT0_MODE);
      chk("wo_read", 0, rdv);
      rreg(12'h001);
      chk("unmapped", RESP_SLVERR, resp);
      wreg(12'h001, 32'h1);
      chk("unmapped_wr", RESP_SLVERR, resp);
      $display("test regs done");
      for (int m = 0; m < 4; m++) begin
         wreg(IDX_EXT0_MODE, m);
         tog(0, 0, f_ext0(m[1:0], 1));
         tog(0, 0, f_ext0(m[1:0], 0));
      end
      for (int s = 0; s < 2; s++) begin
         wreg(IDX_EXT1_MODE, s);
         wreg(IDX_EXT2_MODE, s);
         tog(1, 1, s == 0);
         tog(1, 1, s == 1);
         tog(2, 2, s == 0);
         tog(2, 2, s == 1);
      end
      $display("test ext done");
      // pins rest at idle before the mode is written
      for (int k = 0; k < 8; k++) begin
         p = $urandom_range(7);
         lvl[10:3] <= {8{~k[2]}};
         cyc(6);
         wreg(IDX_KEY_MODE, k);
         clr;
         tog(3 + p, 3, f_key(k[1:0], p));
         tog(3 + p, 3, 0);
      end
      kdir <= 8'h01 << p;
      lvl[10:3] <= 8'h00;
      cyc(6);
      wreg(IDX_KEY_MODE, 7);
      clr;
      tog(3 + p, 3, 0);
      tog(3 + p, 3, 1);
      kdir <= 8'h00;
      $display("test key done");
      wreg(IDX_WATCH, 2);
      pulse;
      cyc(20);
      chk("wreq", 1, wreq);
      rreg(IDX_WATCH);
      chk("watch", 3, rdv);
      wreg(IDX_WATCH, 2);
      rreg(IDX_WATCH);
      chk("watch_clr", 2, rdv);
      wreg(IDX_WATCH, 0);
      pulse;
      chk("wgate", 0, wreq);
      rreg(IDX_WATCH);
      chk("watch_set", 1, rdv);
      // a tick while the clock enable is low must leave the flag alone
      wreg(IDX_WATCH, 0);
      ce <= 0;
      pulse;
      ce <= 1;
      rreg(IDX_WATCH);
      chk("ce_freeze", 0, rdv);
      $display("test watch done");
      wreg(IDX_IRQ_STAT, 32'h1f);
      rreg(IDX_IRQ_STAT);
      chk("stat_clr", 0, rdv);
      wreg(IDX_IRQ_MASK, 32'h10);
      pulse;
      chk("irq", 1, irq);
      wreg(IDX_IRQ_STAT, 32'h10);
      chk("irq_clr", 0, irq);
      wreg(IDX_IRQ_MASK, 0);
      pulse;
      chk("irq_mask", 0, irq);
      rreg(IDX_IRQ_STAT);
      chk("stat", 32'h10, rdv);
      // low byte lane off: the write is dropped
      ws <= 4'he;
      wreg(IDX_IRQ_MASK, 32'h1f);
      ws <= 4'hf;
      rreg(IDX_IRQ_MASK);
      chk("strb_off", 0, rdv);
      $display("test irq done");
      end_of_test;
   end

   // hang guard, far beyond the fewer than one thousand cycles used
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_of_test;
   end
endmodule
`default_nettype wire
